// [logic/ilp_pkg.sv]
// constants and types shared by the four-level interrupt priority block
package ilp_pkg;
    localparam int SRC_COUNT = 7;
    localparam int LEVEL_COUNT = 4;
    // special-function register addresses
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_PRIO_HIGH = 8'hb7;
    localparam logic [7:0] ADDR_PRIO_LOW = 8'hb6;
    // values after reset
    localparam logic [7:0] RESET_IRQ_ENABLE = 8'h00;
    localparam logic [6:0] RESET_PRIO = 7'h00;
    localparam logic [3:0] RESET_IN_SERVICE = 4'h0;
    // enable register bit positions; source index equals its enable bit
    localparam int BIT_EXT0 = 0;
    localparam int BIT_TIMER0 = 1;
    localparam int BIT_EXT1 = 2;
    localparam int BIT_TIMER1 = 3;
    localparam int BIT_SERIAL = 4;
    localparam int BIT_TIMER2 = 5;
    localparam int BIT_COUNTER_ARRAY = 6;
    localparam int BIT_GLOBAL_EN = 7;
    // polling order: entry p holds the source index polled p-th
    localparam logic [6:0][2:0] POLL_ORDER = {3'h5, 3'h4, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
    // vector address per source index
    localparam logic [6:0][7:0] VECTOR_TABLE =
        {8'h33, 8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03};
    // flags cleared on vectoring: always, or only when transition triggered
    localparam logic [6:0] HW_CLEAR_ALWAYS = 7'h0a;
    localparam logic [6:0] HW_CLEAR_IF_EDGE = 7'h05;

    typedef logic [1:0] ilp_level_t;
    typedef logic [2:0] ilp_src_t;
    typedef enum logic [1:0] {
        ILP_IDLE,
        ILP_OFFER,
        ILP_SETTLE
    } ilp_state_e;
endpackage

// [logic/ilp_sfr.sv]
// enable and priority registers on the special-function register port
`timescale 1ns/100ps
module ilp_sfr (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    output logic [7:0] enableQ,
    output logic [6:0] prioHighQ,
    output logic [6:0] prioLowQ
);
    logic [7:0] rdataD;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enableQ <= ilp_pkg::RESET_IRQ_ENABLE;
        end else if (sfrWrite && sfrAddr == ilp_pkg::ADDR_IRQ_ENABLE) begin
            enableQ <= sfrWdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prioHighQ <= ilp_pkg::RESET_PRIO;
        end else if (sfrWrite && sfrAddr == ilp_pkg::ADDR_PRIO_HIGH) begin
            prioHighQ <= sfrWdata[6:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prioLowQ <= ilp_pkg::RESET_PRIO;
        end else if (sfrWrite && sfrAddr == ilp_pkg::ADDR_PRIO_LOW) begin
            prioLowQ <= sfrWdata[6:0];
        end
    end

    // unused top bit of priority registers and unmapped addresses read zero
    always_comb begin
        unique case (sfrAddr)
            ilp_pkg::ADDR_IRQ_ENABLE: rdataD = enableQ;
            ilp_pkg::ADDR_PRIO_HIGH: rdataD = {1'b0, prioHighQ};
            ilp_pkg::ADDR_PRIO_LOW: rdataD = {1'b0, prioLowQ};
            default: rdataD = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfrRdata <= 8'h00;
        end else begin
            sfrRdata <= rdataD;
        end
    end
endmodule

// [logic/ilp_level_stack.sv]
// in-service level tracking, one bit per priority level
`timescale 1ns/100ps
module ilp_level_stack (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire ilp_pkg::ilp_level_t pushLevel,
    input wire logic pop,
    output logic [3:0] inServiceQ,
    output logic activeValid,
    output ilp_pkg::ilp_level_t activeLevel
);
    logic [3:0] inServiceD;

    // nesting can only climb, so the highest set bit is the running handler
    always_comb begin
        activeValid = |inServiceQ;
        activeLevel = 2'h0;
        for (int l = 0; l < ilp_pkg::LEVEL_COUNT; l++) begin
            if (inServiceQ[l]) begin
                activeLevel = l[1:0];
            end
        end
    end

    always_comb begin
        inServiceD = inServiceQ;
        if (pop && activeValid) begin
            inServiceD[activeLevel] = 1'b0;
        end
        if (push) begin
            inServiceD[pushLevel] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inServiceQ <= ilp_pkg::RESET_IN_SERVICE;
        end else begin
            inServiceQ <= inServiceD;
        end
    end
endmodule

// [logic/ilp_arbiter.sv]
// four-level interrupt arbiter: gating, level select, polling, vectoring
`timescale 1ns/100ps
module ilp_arbiter (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic [6:0] srcRequest,
    input wire logic [1:0] extEdgeMode,
    input wire logic vectorAck,
    input wire logic retiPulse,
    output logic irqReq,
    output logic [7:0] irqVector,
    output ilp_pkg::ilp_level_t irqLevel,
    output logic [6:0] clearFlag,
    output logic [6:0] pendingMask,
    output logic [3:0] inServiceLevels
);
    logic [7:0] enableQ;
    logic [6:0] prioHighQ;
    logic [6:0] prioLowQ;
    logic [6:0] eligible;
    ilp_pkg::ilp_level_t srcLevel [ilp_pkg::SRC_COUNT];
    logic winValid;
    ilp_pkg::ilp_src_t winSrc;
    ilp_pkg::ilp_level_t winLevel;
    ilp_pkg::ilp_src_t pollIdx;
    logic winAllowed;
    logic activeValid;
    ilp_pkg::ilp_level_t activeLevel;
    ilp_pkg::ilp_state_e stateQ;
    ilp_pkg::ilp_state_e stateD;
    ilp_pkg::ilp_src_t srcQ;
    ilp_pkg::ilp_level_t levelQ;
    logic [7:0] vectorQ;
    logic [6:0] clearQ;
    logic [6:0] pendingQ;
    logic taken;
    logic [6:0] clearMask;

    ilp_sfr u_sfr (
        .clk(clk),
        .rst(rst),
        .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite),
        .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata),
        .enableQ(enableQ),
        .prioHighQ(prioHighQ),
        .prioLowQ(prioLowQ)
    );

    ilp_level_stack u_stack (
        .clk(clk),
        .rst(rst),
        .push(taken),
        .pushLevel(levelQ),
        .pop(retiPulse),
        .inServiceQ(inServiceLevels),
        .activeValid(activeValid),
        .activeLevel(activeLevel)
    );

    // per-source gating and level
    for (genvar i = 0; i < ilp_pkg::SRC_COUNT; i++) begin : g_src
        assign eligible[i] = enableQ[ilp_pkg::BIT_GLOBAL_EN] && enableQ[i] && srcRequest[i];
        assign srcLevel[i] = {prioHighQ[i], prioLowQ[i]};
        // no enabled request may sit above the chosen one
        chk_win_top: assert property (@(posedge clk) disable iff (rst)
            eligible[i] |-> winValid && srcLevel[i] <= winLevel
        ) else $error("winner below an eligible request");
    end

    // strict compare keeps the earlier-polled source on a level tie
    always_comb begin
        winValid = 1'b0;
        winSrc = 3'h0;
        winLevel = 2'h0;
        pollIdx = 3'h0;
        for (int p = 0; p < ilp_pkg::SRC_COUNT; p++) begin
            pollIdx = ilp_pkg::POLL_ORDER[p];
            if (eligible[pollIdx] && (!winValid || srcLevel[pollIdx] > winLevel)) begin
                winValid = 1'b1;
                winSrc = pollIdx;
                winLevel = srcLevel[pollIdx];
            end
        end
    end

    // equal level is held back, only a strictly higher one pre-empts
    assign winAllowed = winValid && (!activeValid || winLevel > activeLevel);

    assign taken = (stateQ == ilp_pkg::ILP_OFFER) && vectorAck;
    assign irqReq = (stateQ == ilp_pkg::ILP_OFFER);
    assign irqVector = vectorQ;
    assign irqLevel = levelQ;
    assign clearFlag = clearQ;
    assign pendingMask = pendingQ;

    // one settle cycle after an ack lets the stack and the flag clear land
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            ilp_pkg::ILP_IDLE: begin
                if (winAllowed) begin
                    stateD = ilp_pkg::ILP_OFFER;
                end
            end
            ilp_pkg::ILP_OFFER: begin
                if (vectorAck) begin
                    stateD = ilp_pkg::ILP_SETTLE;
                end else if (!winAllowed) begin
                    stateD = ilp_pkg::ILP_IDLE;
                end
            end
            ilp_pkg::ILP_SETTLE: begin
                stateD = ilp_pkg::ILP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateQ <= ilp_pkg::ILP_IDLE;
        end else begin
            stateQ <= stateD;
        end
    end

    // offered source may be replaced by a better one until the ack
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            srcQ <= 3'h0;
            levelQ <= 2'h0;
            vectorQ <= 8'h00;
        end else if (winAllowed && !taken) begin
            srcQ <= winSrc;
            levelQ <= winLevel;
            vectorQ <= ilp_pkg::VECTOR_TABLE[winSrc];
        end
    end

    assign clearMask = ilp_pkg::HW_CLEAR_ALWAYS
        | (ilp_pkg::HW_CLEAR_IF_EDGE & {4'h0, extEdgeMode[1], 1'b0, extEdgeMode[0]});

    // level-triggered external flags stay set so the pin state is re-sampled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clearQ <= 7'h00;
        end else if (taken) begin
            clearQ <= clearMask & (7'h01 << srcQ);
        end else begin
            clearQ <= 7'h00;
        end
    end

    // requests that are enabled but not the one on offer wait here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pendingQ <= 7'h00;
        end else if (irqReq) begin
            pendingQ <= eligible & ~(7'h01 << srcQ);
        end else begin
            pendingQ <= eligible;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_global_gate: assert property (
        !enableQ[ilp_pkg::BIT_GLOBAL_EN] |=> !irqReq
    ) else $error("request offered while globally disabled");

    chk_level_block: assert property (
        irqReq |-> (!activeValid || levelQ > activeLevel)
    ) else $error("request offered at or below the in-service level");

    chk_vector_map: assert property (
        irqReq |-> vectorQ == ilp_pkg::VECTOR_TABLE[srcQ]
    ) else $error("vector does not match the offered source");

    chk_level_form: assert property (
        (stateQ == ilp_pkg::ILP_IDLE && winAllowed && !taken)
            |=> levelQ == {$past(prioHighQ[winSrc]), $past(prioLowQ[winSrc])}
    ) else $error("offered level not formed from the priority bits");

    chk_mask_source: assert property (
        irqReq |-> ($past(eligible) & (7'h01 << srcQ)) != 7'h00
    ) else $error("masked source offered");

    chk_push_ack: assert property (
        taken |=> inServiceLevels[$past(levelQ)] ##1 !irqReq
    ) else $error("acknowledged level not marked in service");

    chk_pop_reti: assert property (
        (retiPulse && !taken && activeValid) |=> !inServiceLevels[$past(activeLevel)]
    ) else $error("return did not release the running level");

    chk_clear_timer: assert property (
        (taken && ilp_pkg::HW_CLEAR_ALWAYS[srcQ]) |=> clearFlag == (7'h01 << $past(srcQ))
    ) else $error("timer flag not cleared on vectoring");

    chk_clear_never: assert property (
        clearFlag[6:4] == 3'h0 && (!clearFlag[0] || $past(extEdgeMode[0]))
            && (!clearFlag[2] || $past(extEdgeMode[1]))
    ) else $error("flag cleared that hardware must leave");

    chk_pending_wait: assert property (
        (eligible[0] && !irqReq && activeValid && srcLevel[0] <= activeLevel)
            |=> pendingMask[0]
    ) else $error("blocked request not held pending");

    chk_clear_after_ack: assert property (
        clearFlag != 7'h00 |-> $past(taken) && $onehot(clearFlag)
    ) else $error("flag clear without a vectoring");

    chk_clear_edge0: assert property (
        (taken && srcQ == 3'(ilp_pkg::BIT_EXT0) && extEdgeMode[0])
            |=> clearFlag == (7'h01 << ilp_pkg::BIT_EXT0)
    ) else $error("edge triggered external 0 flag not cleared");

    chk_clear_edge1: assert property (
        (taken && srcQ == 3'(ilp_pkg::BIT_EXT1) && extEdgeMode[1])
            |=> clearFlag == (7'h01 << ilp_pkg::BIT_EXT1)
    ) else $error("edge triggered external 1 flag not cleared");

    // an allowed offer must stand until the core takes it
    chk_offer_hold: assert property (
        (irqReq && !vectorAck && winAllowed) |=> irqReq
    ) else $error("allowed offer withdrawn before the ack");

    chk_offer_drop: assert property (
        (irqReq && !vectorAck && !winAllowed) |=> !irqReq
    ) else $error("disallowed offer kept standing");

    chk_idle_raise: assert property (
        (stateQ == ilp_pkg::ILP_IDLE && winAllowed) |=> irqReq
    ) else $error("allowed request not offered");

    chk_stack_hold: assert property (
        (!taken && !retiPulse) |=> $stable(inServiceLevels)
    ) else $error("in-service levels changed without ack or return");

    chk_pop_empty: assert property (
        (retiPulse && !taken && !activeValid) |=> inServiceLevels == 4'h0
    ) else $error("return with nothing in service changed the stack");

    // external 0 is polled first, so it wins every tie at its level
    chk_poll_first: assert property (
        (winValid && eligible[ilp_pkg::BIT_EXT0]
            && srcLevel[ilp_pkg::BIT_EXT0] == winLevel)
            |-> winSrc == 3'(ilp_pkg::BIT_EXT0)
    ) else $error("external 0 lost a tie it polls first in");

    chk_win_eligible: assert property (
        winValid |-> eligible[winSrc]
    ) else $error("winner is not an enabled request");

    chk_enable_write: assert property (
        (sfrWrite && sfrAddr == ilp_pkg::ADDR_IRQ_ENABLE) |=> enableQ == $past(sfrWdata)
    ) else $error("enable register write lost");

    chk_high_write: assert property (
        (sfrWrite && sfrAddr == ilp_pkg::ADDR_PRIO_HIGH)
            |=> prioHighQ == $past(sfrWdata[6:0])
    ) else $error("high priority register write lost");
endmodule

// [verif/ilp_core_model.sv]
// behavioural core sequencer: takes offered vectors and issues returns
`timescale 1ns/100ps
module ilp_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irqReq,
    input wire logic [7:0] irqVector,
    input wire logic [3:0] ackDelay,
    input wire logic retireNow,
    output logic vectorAck,
    output logic retiPulse,
    output logic [7:0] lastVector,
    output logic [7:0] takenCount
);
    logic [3:0] waitQ;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vectorAck <= 1'b0;
            retiPulse <= 1'b0;
            lastVector <= 8'h00;
            takenCount <= 8'h00;
            waitQ <= 4'h0;
        end else begin
            // slow acks let the offer be seen standing for several cycles
            waitQ <= irqReq ? waitQ + 4'h1 : 4'h0;
            vectorAck <= irqReq && !vectorAck && waitQ >= ackDelay;
            if (irqReq && vectorAck) begin
                lastVector <= irqVector;
                takenCount <= takenCount + 8'h01;
            end
            retiPulse <= retireNow;
        end
    end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the four-level interrupt arbiter
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, sfrWrite = 1'b0, retireNow = 1'b0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, irqVector, lastVector, takenCount;
    logic [6:0] srcRequest = 7'h00, clearFlag, pendingMask, clrAcc = 7'h00, pend;
    logic [1:0] extEdgeMode = 2'h1;
    logic [3:0] ackDelay = 4'h0, inServiceLevels;
    logic vectorAck, retiPulse, irqReq;
    ilp_pkg::ilp_level_t irqLevel;
    int errors = 0, checks_done = 0;
    logic [7:0] srcVec [7] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33};
    logic [6:0] clrExp [7] = '{7'h01, 7'h03, 7'h03, 7'h0b, 7'h0b, 7'h0b, 7'h0b};
    int pollSrc [7] = '{0, 1, 2, 3, 6, 4, 5};

    ilp_arbiter ilp_arbiter_inst (.clk(clk), .rst(rst), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .srcRequest(srcRequest), .extEdgeMode(extEdgeMode), .vectorAck(vectorAck),
        .retiPulse(retiPulse), .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel),
        .clearFlag(clearFlag), .pendingMask(pendingMask), .inServiceLevels(inServiceLevels));
    ilp_core_model ilp_core_model_inst (.clk(clk), .rst(rst), .irqReq(irqReq),
        .irqVector(irqVector), .ackDelay(ackDelay), .retireNow(retireNow),
        .vectorAck(vectorAck), .retiPulse(retiPulse), .lastVector(lastVector),
        .takenCount(takenCount));

    always #10 clk = ~clk;
    // clear pulses last one cycle, so they are gathered rather than sampled
    // reset empties it, else an unknown before the first edge would stick
    always @(posedge clk) clrAcc <= rst ? 7'h00 : (clrAcc | clearFlag);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr <= a;
        sfrWrite <= 1'b1;
        sfrWdata <= d;
        @(posedge clk);
        sfrWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfrAddr <= a;
        @(posedge clk);
        @(negedge clk);
        check(sfrRdata, exp);
    endtask
    task automatic req(input logic [6:0] r);
        @(posedge clk);
        srcRequest <= r;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic take(input logic [7:0] exp);
        logic [7:0] n;
        n = takenCount;
        for (int i = 0; i < 60 && takenCount === n; i++) @(negedge clk);
        check(takenCount, n + 8'h01);
        check(lastVector, exp);
    endtask
    task automatic retire();
        @(posedge clk);
        retireNow <= 1'b1;
        @(posedge clk);
        retireNow <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #50000;
        errors++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(irqVector, 8'h00);
        check(8'(inServiceLevels), 8'h00);
        rd(8'ha8, 8'h00);
        rd(8'hb7, 8'h00);
        wr(8'ha8, 8'hff);
        rd(8'ha8, 8'hff);
        wr(8'hb7, 8'hff);
        rd(8'hb7, 8'h7f);
        wr(8'hb6, 8'hff);
        rd(8'hb6, 8'h7f);
        wr(8'h55, 8'haa);
        rd(8'h55, 8'h00);
        wr(8'hb7, 8'h00);
        wr(8'hb6, 8'h00);
        wr(8'ha8, 8'h7f);
        req(7'h7f);
        idle(10);
        check(takenCount, 8'h00);
        req(7'h00);
        // one source enabled at a time with every flag raised
        ackDelay <= 4'h5;
        for (int k = 0; k < 7; k++) begin
            wr(8'ha8, 8'h80 | (8'h01 << k));
            req(7'h7f);
            take(srcVec[k]);
            req(7'h00);
            retire();
            idle(3);
            check(8'(clrAcc), 8'(clrExp[k]));
            check(8'(inServiceLevels), 8'h00);
        end
        ackDelay <= 4'h0;
        wr(8'ha8, 8'hff);
        pend = 7'h7f;
        req(pend);
        for (int p = 0; p < 7; p++) begin
            take(srcVec[pollSrc[p]]);
            pend[pollSrc[p]] = 1'b0;
            req(pend);
            retire();
        end
        // levels: serial 3, timer2 2, timer1 1, the rest 0
        wr(8'hb7, 8'h30);
        wr(8'hb6, 8'h18);
        req(7'h01);
        take(8'h03);
        req(7'h08);
        take(8'h1b);
        check(8'(irqLevel), 8'h01);
        req(7'h04);
        idle(8);
        check(8'(inServiceLevels), 8'h03);
        check(8'(irqReq), 8'h00);
        check(8'(pendingMask), 8'h04);
        req(7'h34);
        take(8'h23);
        check(8'(irqLevel), 8'h03);
        check(8'(inServiceLevels), 8'h0b);
        req(7'h24);
        retire();
        take(8'h2b);
        check(8'(irqLevel), 8'h02);
        check(8'(inServiceLevels), 8'h07);
        req(7'h04);
        retire();
        retire();
        idle(6);
        check(8'(inServiceLevels), 8'h01);
        check(8'(irqReq), 8'h00);
        retire();
        take(8'h13);
        req(7'h00);
        // second reset mid-run, then external 0 level and external 1 edge triggered
        extEdgeMode <= 2'h2;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(8'(inServiceLevels), 8'h00);
        check(8'(clrAcc), 8'h00);
        wr(8'ha8, 8'h85);
        req(7'h05);
        take(8'h03);
        req(7'h04);
        retire();
        take(8'h13);
        req(7'h00);
        retire();
        idle(3);
        check(8'(clrAcc), 8'h04);
        end_of_test();
    end
endmodule
